/* test/tb_top.sv */
// self-checking bench for the serial port: bus, frames, flags, interrupt
// assumes usp_remote as far end and a 200 MHz clock
`timescale 1ns/1ps
`include "usp_consts.svh"
module tb_top;
  typedef struct {
    logic [7:0] ctrl;
    logic cfg;
    int cpb;
    logic [7:0] td;
    logic [7:0] rd;
    logic r9;
    logic rf;
  } usp_row_type;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [`USP_ADDR_W-1:0] s_axi_awaddr_in = '0;
  logic [`USP_ADDR_W-1:0] s_axi_araddr_in = '0;
  logic [31:0] s_axi_wdata_in = '0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'b0;
  logic s_axi_wvalid_in = 1'b0;
  logic s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0;
  logic s_axi_rready_in = 1'b0;
  logic baud_ovf_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, rxd_out, rxd_oe_out, txd_out, irq_out, line;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, resp;
  logic [31:0] s_axi_rdata_out, d;
  logic [10:0] got;
  wire logic rxd_in = rxd_oe_out ? rxd_out : line;
  int n_errors = 0;
  int checks = 0;
  usp_row_type r;
  usp_row_type rows [7] = '{
    '{8'h50, 1'b0, 32, 8'hA5, 8'h5A, 1'b0, 1'b1},
    '{8'h70, 1'b0, 32, 8'h0F, 8'h33, 1'b0, 1'b0},
    '{8'h98, 1'b0, 64, 8'hC3, 8'h96, 1'b1, 1'b1},
    '{8'h90, 1'b1, 32, 8'h01, 8'h80, 1'b0, 1'b1},
    '{8'hF0, 1'b0, 32, 8'hFF, 8'h44, 1'b0, 1'b0},
    '{8'hF8, 1'b0, 32, 8'h7E, 8'hE1, 1'b1, 1'b1},
    '{8'h40, 1'b0, 32, 8'h55, 8'h22, 1'b1, 1'b0}};
  usp_top uut (.*);
  usp_remote rem (.core_clk_in(core_clk_in), .txd_in(txd_out), .line_out(line));
  always #2.5 core_clk_in = ~core_clk_in;
  // sixteen overflow pulses make a 32-cycle bit
  always @(posedge core_clk_in) baud_ovf_in <= ~baud_ovf_in;
  // ****************************************
  // bus tasks
  // ****************************************
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [10:0] frm(input logic m9, input logic b9, input logic [7:0] v);
    return m9 ? {1'b1, b9, v, 1'b0} : {1'b0, b9, v, 1'b0};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, v};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    fork
      begin
        do @(posedge core_clk_in); while (!s_axi_awready_out);
        s_axi_awvalid_in <= 1'b0;
      end
      begin
        do @(posedge core_clk_in); while (!s_axi_wready_out);
        s_axi_wvalid_in <= 1'b0;
      end
    join
    while (s_axi_bvalid_out !== 1'b1) @(posedge core_clk_in);
    resp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do @(posedge core_clk_in); while (!s_axi_arready_out);
    s_axi_arvalid_in <= 1'b0;
    while (s_axi_rvalid_out !== 1'b1) @(posedge core_clk_in);
    d = s_axi_rdata_out;
    resp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    #400us;
    n_errors++;
    conclude();
  end
  initial begin
    realtime t0;
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    foreach (rows[i]) begin
      r = rows[i];
      wr(ad(`USP_IDX_CFG), {7'h0, r.cfg});
      wr(ad(`USP_IDX_CTRL), r.ctrl);
      chk("ctrl resp", resp, `USP_RESP_OKAY);
      wr(ad(`USP_IDX_DATA), r.td);
      fork
        rem.grab(got, r.ctrl[7] ? 11 : 10, r.cpb);
        rem.send(frm(r.ctrl[7], r.r9, r.rd), r.ctrl[7] ? 11 : 10, r.cpb);
      join
      repeat (2 * r.cpb) @(posedge core_clk_in);
      chk("tx frame", got, frm(r.ctrl[7], r.ctrl[7] ? r.ctrl[3] : 1'b1, r.td));
      rd(ad(`USP_IDX_CTRL));
      chk("flags", {d[7:3], d[1:0]}, {r.ctrl[7:3], 1'b1, r.rf});
      if (r.rf) begin
        chk("rx ninth", d[2], r.r9);
        rd(ad(`USP_IDX_DATA));
        chk("rx data", d, r.rd);
      end
      $display("row %0d done", i);
    end
    wr(ad(`USP_IDX_CTRL), 8'h50);
    rem.send(frm(1'b0, 1'b1, 8'h11), 10, 32);
    rem.send(frm(1'b0, 1'b1, 8'h22), 10, 32);
    repeat (64) @(posedge core_clk_in);
    rd(ad(`USP_IDX_DATA));
    chk("overwrite", d, 32'h22);
    rd(ad(`USP_IDX_CTRL));
    chk("rx flag kept", d[0], 1'b1);
    $display("overrun done");
    wr(ad(`USP_IDX_IRQ_CLR), 8'h07);
    wr(ad(`USP_IDX_IRQ_EN), 8'h00);
    wr(ad(`USP_IDX_CTRL), 8'h00);
    wr(ad(`USP_IDX_DATA), 8'h6B);
    for (int k = 0; k < 8; k++) begin
      @(posedge txd_out);
      got[k] = rxd_out;
      if (k == 0) t0 = $realtime;
    end
    chk("shift rate", 32'($rtoi($realtime - t0)), 32'd70);
    chk("shift data", got[7:0], 8'h6B);
    repeat (8) @(posedge core_clk_in);
    chk("irq masked", irq_out, 1'b0);
    rd(ad(`USP_IDX_IRQ_STAT));
    chk("tx event", d[0], 1'b1);
    wr(ad(`USP_IDX_IRQ_EN), 8'h01);
    repeat (2) @(posedge core_clk_in);
    chk("irq on", irq_out, 1'b1);
    wr(ad(`USP_IDX_IRQ_CLR), 8'h01);
    repeat (2) @(posedge core_clk_in);
    chk("irq off", irq_out, 1'b0);
    rd(ad(`USP_IDX_CTRL));
    chk("tx flag kept", d[1], 1'b1);
    rd(12'h000);
    chk("unmapped", {d[29:0], resp}, {30'h0, `USP_RESP_SLVERR});
    $display("mode 0 and bus done");
    reset_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(ad(`USP_IDX_CTRL));
    chk("ctrl reset", d, 32'h0);
    chk("line idle", txd_out, 1'b1);
    $display("reset done");
    conclude();
  end
endmodule

/* test/usp_checker.sv */
// assertions on the serial port's bus handshake and pins
// assumes it is bound into usp_top, one clock domain
`timescale 1ns/1ps
module usp_checker (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // bus
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // pins
  input wire logic rxd_out,
  input wire logic rxd_oe_out,
  input wire logic txd_out,
  input wire logic irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  bresp_hold_a:
  assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
    && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  rdata_hold_a:
  assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
    && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  write_lat_a:
  assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  read_lat_a:
  assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  busy_ready_a:
  assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
    else $error("address ready while address held");
  idle_line_a:
  assert property ($fell(reset_in) |-> txd_out && !rxd_oe_out && !irq_out)
    else $error("pins not idle after reset");
  shift_clk_a:
  assert property (rxd_oe_out && !txd_out |=> txd_out) else $error("shift clock slow");
  shift_data_a:
  assert property (rxd_oe_out && !txd_out |=> $stable(rxd_out))
    else $error("shift data moved mid bit");
  cover property (s_axi_bvalid_out && s_axi_bready_in);
  cover property (rxd_oe_out);
  cover property ($rose(irq_out));
endmodule
bind usp_top usp_checker chk (.*);

/* test/usp_remote.sv */
// far-end serial device: drives the receive line, samples the transmit line
// assumes bit times are given in core clock cycles
`timescale 1ns/1ps
module usp_remote (
  // clock
  input wire logic core_clk_in,
  // serial lines
  input wire logic txd_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // bits go out from bit 0, line idles high after the stop bit
  task automatic send(input logic [10:0] f, input int n, input int cpb);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (cpb) @(posedge core_clk_in);
    end
    line_out <= 1'b1;
    @(posedge core_clk_in);
  endtask
  // waits for the start edge, then samples each bit at its middle
  task automatic grab(output logic [10:0] f, input int n, input int cpb);
    int w;
    f = '0;
    w = 0;
    while (txd_in && w < 5000) begin
      @(posedge core_clk_in);
      w++;
    end
    repeat (cpb / 2) @(posedge core_clk_in);
    for (int i = 0; i < n; i++) begin
      f[i] = txd_in;
      repeat (cpb) @(posedge core_clk_in);
    end
  endtask
endmodule

/* verilog/usp_consts.svh */
// constants for the serial port block: offsets, fields, resets, rates
// assumes a single 200 MHz core clock and an AXI4-Lite register bus
// Behaviour
// RULE1: data port write loads transmitter; a read returns the separate receive buffer
// RULE2: mode bits 7:6 select shift, 8-bit variable, 9-bit fixed, 9-bit variable
// RULE3: shift-register mode runs at core clock divided by two
// RULE4: 9-bit fixed mode runs at core clock /64, or /32 when doubled
// RULE5: 8-bit mode with filter set: no receive flag without valid stop bit
// RULE6: 9-bit modes with filter set: no receive flag when ninth bit is 0
// RULE7: filter clear: receive flag raised whenever a byte arrives
// RULE8: software keeps address filter clear in shift-register mode
// RULE9: reception only while receive enable is set; a started shift-mode reception runs to its eighth bit if enable clears
// RULE10: 9-bit modes send the transmit ninth-bit field as ninth bit
// RULE11: receive ninth-bit field takes ninth bit, or stop bit in 8-bit mode
// RULE12: transmit flag set after eighth shift bit, else at stop bit start
// RULE13: transmit flag is cleared only by software
// RULE14: receive flag set after eighth shift bit, else mid stop bit
// RULE15: receive flag is cleared only by software
// RULE16: receive path double buffered; an unread byte is overwritten
// RULE17: shift-mode reception starts only with enable 1 and flag 0
// RULE18: 8-bit frame is start 0, eight data bits LSB first, stop 1
// RULE19: variable-rate modes time bits from an external overflow pulse
`ifndef USP_CONSTS_SVH
`define USP_CONSTS_SVH

// register indices, byte address is four times the index
`define USP_IDX_CTRL 10'h098
`define USP_IDX_DATA 10'h099
`define USP_IDX_IRQ_STAT 10'h09A
`define USP_IDX_IRQ_CLR 10'h09B
`define USP_IDX_IRQ_EN 10'h09C
`define USP_IDX_CFG 10'h09D
`define USP_ADDR_W 12
// control register fields
`define USP_F_MODE_HI 7
`define USP_F_MODE_LO 6
`define USP_F_FILT 5
`define USP_F_REN 4
`define USP_F_TB8 3
`define USP_F_RB8 2
`define USP_F_TXF 1
`define USP_F_RXF 0
`define USP_CTRL_RESET 8'h00
// interrupt status fields
`define USP_I_TX 0
`define USP_I_RX 1
`define USP_I_OVR 2
`define USP_IRQ_W 3
// rates: bits are split into 16 sample ticks
`define USP_OVS 16
`define USP_M2_DIV 64
`define USP_M2_DIV_DBL 32
`define USP_M2_TICK (`USP_M2_DIV / `USP_OVS)
`define USP_M2_TICK_DBL (`USP_M2_DIV_DBL / `USP_OVS)

// bus answers
`define USP_RESP_OKAY 2'h0
`define USP_RESP_SLVERR 2'h2

`endif

/* verilog/usp_pkg.sv */
// types shared by the serial port modules
// assumes usp_consts.svh is compiled alongside
package usp_pkg;
  typedef enum logic [1:0] {USP_SHIFT, USP_ASYNC8, USP_FIX9, USP_VAR9} usp_mode_type;
  typedef enum logic [1:0] {USP_IDLE, USP_SHIFT_RUN, USP_ASYNC_RUN} usp_state_type;
endpackage

/* verilog/usp_rx.sv */
// receive shifter for all four modes
// assumes rxd_in is already synchronised and tick16_in is a one-cycle pulse
`timescale 1ns/1ps
`include "usp_consts.svh"
module usp_rx
  import usp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // control
  input wire usp_mode_type mode_in,
  input wire logic tick16_in,
  input wire logic en_in,
  input wire logic flag_in,
  // line side
  input wire logic rxd_in,
  output logic sclk_out,
  // received frame
  output logic frame_out,
  output logic [7:0] data_out,
  output logic ninth_out
);
  usp_state_type state_ff;
  logic [3:0] bit_cnt_ff;
  logic [3:0] sub_ff;
  logic phase_ff;
  logic prev_ff;
  logic [3:0] last_bit;

  assign last_bit = (mode_in == USP_ASYNC8) ? 4'h9 : 4'hA;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= USP_IDLE;
      bit_cnt_ff <= 4'h0;
      sub_ff <= 4'h0;
      phase_ff <= 1'b0;
      prev_ff <= 1'b1;
      sclk_out <= 1'b1;
      frame_out <= 1'b0;
      data_out <= 8'h00;
      ninth_out <= 1'b0;
    end else begin
      prev_ff <= rxd_in;
      frame_out <= 1'b0;
      case (state_ff)
        USP_IDLE: begin
          sclk_out <= 1'b1;
          bit_cnt_ff <= 4'h0;
          sub_ff <= 4'h0;
          phase_ff <= 1'b0;
          if (mode_in == USP_SHIFT) begin
            if (en_in && !flag_in && !frame_out) begin
              state_ff <= USP_SHIFT_RUN; // see RULE17 see RULE9
            end
          end else if (en_in && prev_ff && !rxd_in) begin
            state_ff <= USP_ASYNC_RUN; // see RULE9
          end
        end
        USP_SHIFT_RUN: begin
          phase_ff <= ~phase_ff; // see RULE3
          sclk_out <= phase_ff;
          if (phase_ff) begin
            data_out <= {rxd_in, data_out[7:1]};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
              frame_out <= 1'b1; // see RULE14
              state_ff <= USP_IDLE;
            end
          end
        end
        default: begin
          if (!en_in) begin
            state_ff <= USP_IDLE; // see RULE9
          end else if (tick16_in) begin
            sub_ff <= sub_ff + 4'h1;
            // sample at the middle of each bit
            if (sub_ff == 4'h7) begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == 4'h0 && rxd_in) begin
                state_ff <= USP_IDLE;
              end else if (bit_cnt_ff >= 4'h1 && bit_cnt_ff <= 4'h8) begin
                data_out <= {rxd_in, data_out[7:1]}; // see RULE18
              end else if (bit_cnt_ff == 4'h9) begin
                ninth_out <= rxd_in; // see RULE11
              end
              if (bit_cnt_ff == last_bit) begin
                frame_out <= 1'b1; // see RULE14
                state_ff <= USP_IDLE;
              end
            end
          end
        end
      endcase
    end
  end
endmodule

/* verilog/usp_top.sv */
// serial port with control, data port and interrupt over AXI4-Lite
// assumes baud_ovf_in comes from a timer on the same core clock
`timescale 1ns/1ps
`include "usp_consts.svh"
module usp_top
  import usp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // axi4-lite write address
  input wire logic [`USP_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address
  input wire logic [`USP_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // baud source for variable-rate modes
  input wire logic baud_ovf_in,
  // serial pins, receive pin is two-way in shift mode
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_out,
  output logic txd_out,
  // interrupt
  output logic irq_out
);

  // ******************************
  // register state
  // ******************************
  usp_mode_type mode_ff;
  logic filt_ff;
  logic ren_ff;
  logic tb8_ff;
  logic rb8_ff;
  logic txf_ff;
  logic rxf_ff;
  logic dbl_ff;
  logic [7:0] tx_buf_ff;
  logic [7:0] rx_buf_ff;
  logic [`USP_IRQ_W-1:0] irq_stat_ff;
  logic [`USP_IRQ_W-1:0] irq_en_ff;
  logic tx_start_ff;

  // ******************************
  // bus slave state
  // ******************************
  logic aw_full_ff;
  logic w_full_ff;
  logic [`USP_ADDR_W-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // ******************************
  // line and timing state
  // ******************************
  logic sync1_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic rxd_lvl_ff;
  logic [1:0] div_ff;
  logic tick16_ff;
  logic txd_ff;

  // ******************************
  // internal wires
  // ******************************
  logic aw_take;
  logic w_take;
  logic do_write;
  logic do_read;
  logic nxt_aw_full;
  logic nxt_w_full;
  logic nxt_rvalid;
  logic wr_ctrl;
  logic wr_data;
  logic wr_clr;
  logic wr_en;
  logic wr_cfg;
  logic wr_ok;
  logic [31:0] nxt_rdata;
  logic nxt_rresp_err;
  logic [1:0] div_last;
  logic tx_txd;
  logic tx_sdata;
  logic tx_sdata_oe;
  logic tx_done;
  logic rx_sclk;
  logic rx_frame;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_accept;
  logic [`USP_IRQ_W-1:0] irq_event;
  logic [7:0] ctrl_view;

  // ******************************
  // axi4-lite handshakes
  // ******************************
  assign aw_take = s_axi_awvalid_in && awready_ff;
  assign w_take = s_axi_wvalid_in && wready_ff;
  assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
  assign do_read = s_axi_arvalid_in && arready_ff;
  assign nxt_aw_full = aw_take || (aw_full_ff && !do_write);
  assign nxt_w_full = w_take || (w_full_ff && !do_write);
  assign nxt_rvalid = do_read || (rvalid_ff && !s_axi_rready_in);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `USP_RESP_OKAY;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awready_ff <= !nxt_aw_full;
      wready_ff <= !nxt_w_full;
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr_in;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata_in;
        w_strb_ff <= s_axi_wstrb_in;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `USP_RESP_OKAY : `USP_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `USP_RESP_OKAY;
      rdata_ff <= 32'h0;
    end else begin
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (do_read) begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp_err ? `USP_RESP_SLVERR : `USP_RESP_OKAY;
      end
    end
  end

  // ******************************
  // address decode
  // ******************************
  always_comb begin
    wr_ctrl = 1'b0;
    wr_data = 1'b0;
    wr_clr = 1'b0;
    wr_en = 1'b0;
    wr_cfg = 1'b0;
    wr_ok = 1'b1;
    if (aw_addr_ff == {`USP_IDX_CTRL, 2'h0}) begin
      wr_ctrl = do_write && w_strb_ff[0];
    end else if (aw_addr_ff == {`USP_IDX_DATA, 2'h0}) begin
      wr_data = do_write && w_strb_ff[0];
    end else if (aw_addr_ff == {`USP_IDX_IRQ_CLR, 2'h0}) begin
      wr_clr = do_write && w_strb_ff[0];
    end else if (aw_addr_ff == {`USP_IDX_IRQ_EN, 2'h0}) begin
      wr_en = do_write && w_strb_ff[0];
    end else if (aw_addr_ff == {`USP_IDX_CFG, 2'h0}) begin
      wr_cfg = do_write && w_strb_ff[0];
    end else if (aw_addr_ff != {`USP_IDX_IRQ_STAT, 2'h0}) begin
      wr_ok = 1'b0;
    end
  end

  assign ctrl_view = {mode_ff, filt_ff, ren_ff, tb8_ff, rb8_ff, txf_ff, rxf_ff};

  always_comb begin
    nxt_rdata = 32'h0;
    nxt_rresp_err = 1'b0;
    if (s_axi_araddr_in == {`USP_IDX_CTRL, 2'h0}) begin
      nxt_rdata = {24'h0, ctrl_view};
    end else if (s_axi_araddr_in == {`USP_IDX_DATA, 2'h0}) begin
      nxt_rdata = {24'h0, rx_buf_ff}; // see RULE1
    end else if (s_axi_araddr_in == {`USP_IDX_IRQ_STAT, 2'h0}) begin
      nxt_rdata = {29'h0, irq_stat_ff};
    end else if (s_axi_araddr_in == {`USP_IDX_IRQ_EN, 2'h0}) begin
      nxt_rdata = {29'h0, irq_en_ff};
    end else if (s_axi_araddr_in == {`USP_IDX_CFG, 2'h0}) begin
      nxt_rdata = {31'h0, dbl_ff};
    end else if (s_axi_araddr_in != {`USP_IDX_IRQ_CLR, 2'h0}) begin
      nxt_rresp_err = 1'b1;
    end
  end

  // ******************************
  // control register
  // ******************************
  // hardware setting a flag wins over a software write in the same cycle
  assign rx_accept = rx_frame && (mode_ff == USP_SHIFT || !filt_ff // see RULE7
    || rx_ninth); // see RULE5 see RULE6

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mode_ff <= USP_SHIFT;
      filt_ff <= 1'b0;
      ren_ff <= 1'b0;
      tb8_ff <= 1'b0;
      dbl_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode_ff <= usp_mode_type'(w_data_ff[`USP_F_MODE_HI:`USP_F_MODE_LO]); // see RULE2
        filt_ff <= w_data_ff[`USP_F_FILT];
        ren_ff <= w_data_ff[`USP_F_REN];
        tb8_ff <= w_data_ff[`USP_F_TB8];
      end
      if (wr_cfg) begin
        dbl_ff <= w_data_ff[0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      txf_ff <= 1'b0;
      rxf_ff <= 1'b0;
    end else begin
      txf_ff <= tx_done || (wr_ctrl ? w_data_ff[`USP_F_TXF] : txf_ff); // see RULE12 see RULE13
      rxf_ff <= rx_accept || (wr_ctrl ? w_data_ff[`USP_F_RXF] : rxf_ff); // see RULE14 see RULE15
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rb8_ff <= 1'b0;
      rx_buf_ff <= 8'h00;
    end else if (rx_accept) begin
      rx_buf_ff <= rx_data; // see RULE16
      if (mode_ff != USP_SHIFT) begin
        rb8_ff <= rx_ninth; // see RULE11
      end
    end else if (wr_ctrl) begin
      rb8_ff <= w_data_ff[`USP_F_RB8];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      tx_buf_ff <= 8'h00;
      tx_start_ff <= 1'b0;
    end else begin
      tx_start_ff <= wr_data;
      if (wr_data) begin
        tx_buf_ff <= w_data_ff[7:0]; // see RULE1
      end
    end
  end

  // ******************************
  // interrupt
  // ******************************
  assign irq_event = {rx_accept && rxf_ff, rx_accept, tx_done};

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_stat_ff <= irq_event | (irq_stat_ff & ~(wr_clr ? w_data_ff[`USP_IRQ_W-1:0] : '0));
      if (wr_en) begin
        irq_en_ff <= w_data_ff[`USP_IRQ_W-1:0];
      end
      irq_out <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ******************************
  // sample tick and pin sync
  // ******************************
  assign div_last = dbl_ff ? 2'(`USP_M2_TICK_DBL - 1) : 2'(`USP_M2_TICK - 1);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      div_ff <= 2'h0;
      tick16_ff <= 1'b0;
    end else begin
      div_ff <= (div_ff >= div_last) ? 2'h0 : div_ff + 2'h1;
      if (mode_ff == USP_FIX9) begin
        tick16_ff <= (div_ff >= div_last); // see RULE4
      end else begin
        tick16_ff <= baud_ovf_in; // see RULE19
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      sync3_ff <= 1'b1;
      rxd_lvl_ff <= 1'b1;
    end else begin
      sync1_ff <= rxd_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        rxd_lvl_ff <= sync3_ff;
      end
    end
  end

  // both shift clocks idle high, so either can pull the line
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      txd_ff <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_out <= 1'b0;
    end else begin
      txd_ff <= tx_txd & rx_sclk;
      rxd_out <= tx_sdata;
      rxd_oe_out <= tx_sdata_oe;
    end
  end

  // ******************************
  // shifters
  // ******************************
  usp_tx u_tx (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .mode_in(mode_ff),
    .tick16_in(tick16_ff),
    .start_in(tx_start_ff),
    .data_in(tx_buf_ff),
    .ninth_in(tb8_ff),
    .txd_out(tx_txd),
    .sdata_out(tx_sdata),
    .sdata_oe_out(tx_sdata_oe),
    .done_out(tx_done)
  );

  usp_rx u_rx (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .mode_in(mode_ff),
    .tick16_in(tick16_ff),
    .en_in(ren_ff),
    .flag_in(rxf_ff),
    .rxd_in(rxd_lvl_ff),
    .sclk_out(rx_sclk),
    .frame_out(rx_frame),
    .data_out(rx_data),
    .ninth_out(rx_ninth)
  );

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out = wready_ff;
  assign s_axi_bvalid_out = bvalid_ff;
  assign s_axi_bresp_out = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out = rvalid_ff;
  assign s_axi_rresp_out = rresp_ff;
  assign s_axi_rdata_out = rdata_ff;
  assign txd_out = txd_ff;

endmodule

/* verilog/usp_tx.sv */
// transmit shifter for all four modes
// assumes tick16_in is one-cycle pulse at sixteen per bit in async modes
`timescale 1ns/1ps
`include "usp_consts.svh"
module usp_tx
  import usp_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // control
  input wire usp_mode_type mode_in,
  input wire logic tick16_in,
  input wire logic start_in,
  input wire logic [7:0] data_in,
  input wire logic ninth_in,
  // line side
  output logic txd_out,
  output logic sdata_out,
  output logic sdata_oe_out,
  output logic done_out
);
  usp_state_type state_ff;
  logic [10:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [3:0] sub_ff;
  logic phase_ff;
  logic [3:0] last_bit;

  assign last_bit = (mode_in == USP_ASYNC8) ? 4'h9 : 4'hA;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_ff <= USP_IDLE;
      shift_ff <= 11'h7FF;
      bit_cnt_ff <= 4'h0;
      sub_ff <= 4'h0;
      phase_ff <= 1'b0;
      txd_out <= 1'b1;
      sdata_out <= 1'b1;
      sdata_oe_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_ff)
        USP_IDLE: begin
          txd_out <= 1'b1;
          sdata_oe_out <= 1'b0;
          bit_cnt_ff <= 4'h0;
          sub_ff <= 4'h0;
          phase_ff <= 1'b0;
          if (start_in && mode_in == USP_SHIFT) begin
            shift_ff <= {3'h7, data_in};
            state_ff <= USP_SHIFT_RUN;
          end else if (start_in) begin
            // see RULE10 see RULE18
            shift_ff <= {1'b1, (mode_in == USP_ASYNC8) ? 1'b1 : ninth_in, data_in, 1'b0};
            state_ff <= USP_ASYNC_RUN;
          end
        end
        USP_SHIFT_RUN: begin
          // two core cycles per bit, clock low then high
          phase_ff <= ~phase_ff; // see RULE3
          sdata_oe_out <= 1'b1;
          sdata_out <= shift_ff[0];
          txd_out <= phase_ff;
          if (phase_ff) begin
            shift_ff <= {1'b1, shift_ff[10:1]};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
              done_out <= 1'b1; // see RULE12
              state_ff <= USP_IDLE;
            end
          end
        end
        default: begin
          txd_out <= shift_ff[0];
          if (tick16_in) begin
            sub_ff <= sub_ff + 4'h1;
            if (sub_ff == 4'hF) begin
              shift_ff <= {1'b1, shift_ff[10:1]};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff + 4'h1 == last_bit) begin
                done_out <= 1'b1; // see RULE12
              end
              if (bit_cnt_ff == last_bit) begin
                state_ff <= USP_IDLE;
              end
            end
          end
        end
      endcase
    end
  end
endmodule
